// >>> include/cpu_exec_pkg.sv
// shared types and constants of the instruction execution block
package cpu_exec_pkg;

  // ****************************************
  // operations
  // ****************************************
  typedef enum logic [3:0] {
    OP_BRANCH_ALWAYS  = 4'h0,
    OP_BRANCH_NEVER   = 4'h1,
    OP_JUMP_INDIRECT  = 4'h2,
    OP_DEC_ADJ_ADD    = 4'h3,
    OP_DEC_ADJ_SUB    = 4'h4,
    OP_FLAGS_XOR      = 4'h5,
    OP_STORE_FLAGS    = 4'h6,
    OP_PUSH           = 4'h7,
    OP_POP            = 4'h8,
    OP_TEST_AND_SET   = 4'h9,
    OP_LOAD_SP        = 4'ha
  } op_code_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } xfer_size_t;

  // ****************************************
  // flag layout and constants
  // ****************************************
  localparam int unsigned FLAG_C      = 7;
  localparam int unsigned FLAG_V      = 6;
  localparam int unsigned FLAG_H      = 5;
  localparam int unsigned FLAG_N      = 3;
  localparam int unsigned FLAG_Z      = 2;
  localparam int unsigned TAS_BIT     = 7;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [7:0]  ODD_FILL    = 8'h00;
  localparam logic [31:0] STACK_STEP  = 32'h0000_0002;
  localparam logic [31:0] EVEN_MASK   = 32'hffff_fffe;
  localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0]  BCD_BYTE_MAX  = 8'h99;
  localparam logic [7:0]  FIX_LOW       = 8'h06;
  localparam logic [7:0]  FIX_HIGH      = 8'h60;

endpackage : cpu_exec_pkg

// >>> include/mem_req_if.sv
// request carrier between the execution core and its bus port
`timescale 1ns/100ps
`default_nettype none
interface mem_req_if;
  logic                     req;
  logic                     we;
  logic                     lock;
  logic [31:0]              addr;
  logic [31:0]              wdata;
  cpu_exec_pkg::xfer_size_t size;
  logic [31:0]              rdata;
  logic                     done;

  modport issuer (output req, we, lock, addr, wdata, size, input rdata, done);
  modport port   (input req, we, lock, addr, wdata, size, output rdata, done);
endinterface : mem_req_if
`default_nettype wire

// >>> logic/decimal_adjust.sv
// decimal correction of a byte from the carry and half-carry flags
`timescale 1ns/100ps
`default_nettype none
module decimal_adjust (
  input  wire logic       subtract_i,
  input  wire logic [7:0] value_i,
  input  wire logic       carry_i,
  input  wire logic       half_i,
  output logic      [7:0] result_o,
  output logic            carry_o
);
  logic       fix_lo;
  logic       fix_hi;
  logic [7:0] fix;

  // ****************************************
  // correction
  // ****************************************
  // only the flags and the value count; the op that left the flags is unknown here
  always_comb
  begin
    if (subtract_i)
    begin
      fix_lo = half_i;
      fix_hi = carry_i;
    end
    else
    begin
      fix_lo = half_i || (value_i[3:0] > cpu_exec_pkg::BCD_DIGIT_MAX);
      fix_hi = carry_i || (value_i > cpu_exec_pkg::BCD_BYTE_MAX);
    end
    fix = (fix_hi ? cpu_exec_pkg::FIX_HIGH : 8'h00) | (fix_lo ? cpu_exec_pkg::FIX_LOW : 8'h00);
    result_o = subtract_i ? value_i - fix : value_i + fix;
    carry_o  = fix_hi;
  end
endmodule : decimal_adjust
`default_nettype wire

// >>> logic/bus_port.sv
// memory bus port with arbitration against other bus masters
`timescale 1ns/100ps
`default_nettype none
module bus_port (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  mem_req_if.port          m,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_addr_o,
  output cpu_exec_pkg::xfer_size_t mem_size_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        ext_bus_req_i,
  output logic             ext_bus_grant_o
);
  logic grant_q;
  logic grant_d;

  // ****************************************
  // arbitration
  // ****************************************
  // a locked sequence never hands the bus over, even between its two accesses
  always_comb
  begin
    if (grant_q)
      grant_d = ext_bus_req_i;
    else
      grant_d = ext_bus_req_i && !m.req && !m.lock;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      grant_q <= 1'b0;
    else
      grant_q <= grant_d;
  end

  // ****************************************
  // bus pins
  // ****************************************
  // request, address and data are flops in the core; held stable until ack
  assign mem_req_o       = m.req && !grant_q;
  assign mem_we_o        = m.we;
  assign mem_addr_o      = m.addr;
  assign mem_size_o      = m.size;
  assign mem_wdata_o     = m.wdata;
  assign m.done          = mem_req_o && mem_ack_i;
  assign m.rdata         = mem_rdata_i;
  assign ext_bus_grant_o = grant_q;
endmodule : bus_port
`default_nettype wire

// >>> logic/cpu_exec_unit.sv
// execution of branch, flag, decimal, stack and test-and-set operations
// Function
// - relative branch target is own address plus displacement
// - short displacement is signed, -128 to +127
// - long displacement is signed, -32768 to +32767
// - indirect jump takes target from operand address
// - branch always: condition true, always taken
// - branch never: condition false, falls through
// - decimal correction uses only carry, half-carry flags
// - xor mask a0 flips carry and half-carry
// - flag store writes even byte, odd byte undefined
// - stack accesses are word or longword only
// - stack pointer has no reset value
// - test-and-set reads byte, writes bit 7 set
// - test-and-set is locked, no bus grant between
`timescale 1ns/100ps
`default_nettype none
module cpu_exec_unit (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        op_valid_i,
  output logic             op_ready_o,
  input  wire cpu_exec_pkg::op_code_t op_code_i,
  input  wire logic        op_wide_i,
  input  wire logic [31:0] op_pc_i,
  input  wire logic [15:0] op_disp_i,
  input  wire logic [31:0] op_addr_i,
  input  wire logic [15:0] op_data_i,
  output logic             done_o,
  output logic             pc_load_o,
  output logic      [31:0] pc_target_o,
  output logic      [15:0] result_o,
  output logic      [7:0]  flags_o,
  output logic      [31:0] sp_o,
  output logic             sp_valid_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_addr_o,
  output cpu_exec_pkg::xfer_size_t mem_size_o,
  output logic      [31:0] mem_wdata_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  input  wire logic        ext_bus_req_i,
  output logic             ext_bus_grant_o
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_TAS_WR = 2'b10
  } state_t;

  mem_req_if              mif ();
  state_t                 state_q;
  cpu_exec_pkg::op_code_t cur_op_q;
  logic                   accept;
  logic [31:0]            disp_ext;
  logic [7:0]             adj_value;
  logic                   adj_carry;
  logic                   req_q;
  logic                   we_q;
  logic                   lock_q;
  logic [31:0]            addr_q;
  logic [31:0]            wdata_q;
  cpu_exec_pkg::xfer_size_t size_q;
  logic [7:0]             flags_q;
  logic [31:0]            sp_q;
  logic                   sp_valid_q;
  logic                   done_q;
  logic                   pc_load_q;
  logic [31:0]            pc_target_q;
  logic [15:0]            result_q;
  logic [7:0]             tas_byte;

  assign accept     = op_valid_i && op_ready_o;
  assign op_ready_o = (state_q == ST_IDLE);
  assign tas_byte   = mif.rdata[7:0];

  // ****************************************
  // displacement and decimal correction
  // ****************************************
  assign disp_ext = op_wide_i ? {{16{op_disp_i[15]}}, op_disp_i}
                              : {{24{op_disp_i[7]}}, op_disp_i[7:0]};

  decimal_adjust u_adjust (
    .subtract_i (op_code_i == cpu_exec_pkg::OP_DEC_ADJ_SUB),
    .value_i    (op_data_i[7:0]),
    .carry_i    (flags_q[cpu_exec_pkg::FLAG_C]),
    .half_i     (flags_q[cpu_exec_pkg::FLAG_H]),
    .result_o   (adj_value),
    .carry_o    (adj_carry)
  );

  bus_port u_bus (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .m               (mif.port),
    .mem_req_o       (mem_req_o),
    .mem_we_o        (mem_we_o),
    .mem_addr_o      (mem_addr_o),
    .mem_size_o      (mem_size_o),
    .mem_wdata_o     (mem_wdata_o),
    .mem_ack_i       (mem_ack_i),
    .mem_rdata_i     (mem_rdata_i),
    .ext_bus_req_i   (ext_bus_req_i),
    .ext_bus_grant_o (ext_bus_grant_o)
  );

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q  <= ST_IDLE;
      cur_op_q <= cpu_exec_pkg::OP_BRANCH_NEVER;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (accept)
          begin
            cur_op_q <= op_code_i;
            if (op_code_i inside {cpu_exec_pkg::OP_STORE_FLAGS, cpu_exec_pkg::OP_PUSH,
                                  cpu_exec_pkg::OP_POP, cpu_exec_pkg::OP_TEST_AND_SET})
              state_q <= ST_ACCESS;
          end
        ST_ACCESS:
          if (mif.done)
            state_q <= (cur_op_q == cpu_exec_pkg::OP_TEST_AND_SET) ? ST_TAS_WR : ST_IDLE;
        ST_TAS_WR:
          if (mif.done)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // memory requests
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      lock_q  <= 1'b0;
      addr_q  <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      size_q  <= cpu_exec_pkg::SIZE_WORD;
    end
    else if (accept)
    begin
      unique case (op_code_i)
        cpu_exec_pkg::OP_STORE_FLAGS:
        begin
          req_q   <= 1'b1;
          we_q    <= 1'b1;
          addr_q  <= op_addr_i & cpu_exec_pkg::EVEN_MASK;
          size_q  <= cpu_exec_pkg::SIZE_WORD;
          wdata_q <= {16'h0000, flags_q, cpu_exec_pkg::ODD_FILL};
        end
        cpu_exec_pkg::OP_PUSH:
        begin
          req_q   <= 1'b1;
          we_q    <= 1'b1;
          addr_q  <= sp_q - cpu_exec_pkg::STACK_STEP;
          size_q  <= cpu_exec_pkg::SIZE_WORD;
          wdata_q <= {16'h0000, op_data_i};
        end
        cpu_exec_pkg::OP_POP:
        begin
          req_q  <= 1'b1;
          we_q   <= 1'b0;
          addr_q <= sp_q;
          size_q <= cpu_exec_pkg::SIZE_WORD;
        end
        cpu_exec_pkg::OP_TEST_AND_SET:
        begin
          req_q  <= 1'b1;
          we_q   <= 1'b0;
          lock_q <= 1'b1;
          addr_q <= op_addr_i;
          size_q <= cpu_exec_pkg::SIZE_BYTE;
        end
        default:
          req_q <= 1'b0;
      endcase
    end
    else if (mif.done)
    begin
      if (state_q == ST_ACCESS && cur_op_q == cpu_exec_pkg::OP_TEST_AND_SET)
      begin
        // write-back stays locked so no other master sees the byte half claimed
        we_q    <= 1'b1;
        wdata_q <= {24'h000000, tas_byte | 8'h80};
      end
      else
      begin
        req_q  <= 1'b0;
        we_q   <= 1'b0;
        lock_q <= 1'b0;
      end
    end
  end

  assign mif.req   = req_q;
  assign mif.we    = we_q;
  assign mif.lock  = lock_q;
  assign mif.addr  = addr_q;
  assign mif.wdata = wdata_q;
  assign mif.size  = size_q;

  // ****************************************
  // condition flags
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      flags_q <= cpu_exec_pkg::FLAGS_RESET;
    else if (accept && op_code_i == cpu_exec_pkg::OP_FLAGS_XOR)
      flags_q <= flags_q ^ op_data_i[7:0];
    else if (accept && op_code_i inside {cpu_exec_pkg::OP_DEC_ADJ_ADD,
                                         cpu_exec_pkg::OP_DEC_ADJ_SUB})
    begin
      flags_q[cpu_exec_pkg::FLAG_C] <= adj_carry;
      flags_q[cpu_exec_pkg::FLAG_N] <= adj_value[7];
      flags_q[cpu_exec_pkg::FLAG_Z] <= (adj_value == 8'h00);
    end
    else if (state_q == ST_ACCESS && mif.done && cur_op_q == cpu_exec_pkg::OP_TEST_AND_SET)
    begin
      // flags show the byte before it was claimed
      flags_q[cpu_exec_pkg::FLAG_N] <= tas_byte[7];
      flags_q[cpu_exec_pkg::FLAG_Z] <= (tas_byte == 8'h00);
      flags_q[cpu_exec_pkg::FLAG_V] <= 1'b0;
    end
  end

  // ****************************************
  // stack pointer
  // ****************************************
  // no reset: contents stay unknown until software loads them
  always_ff @(posedge ref_clk_i)
  begin
    if (accept && op_code_i == cpu_exec_pkg::OP_LOAD_SP)
      sp_q <= op_addr_i;
    else if (accept && op_code_i == cpu_exec_pkg::OP_PUSH)
      sp_q <= sp_q - cpu_exec_pkg::STACK_STEP;
    else if (state_q == ST_ACCESS && mif.done && cur_op_q == cpu_exec_pkg::OP_POP)
      sp_q <= sp_q + cpu_exec_pkg::STACK_STEP;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sp_valid_q <= 1'b0;
    else if (accept && op_code_i == cpu_exec_pkg::OP_LOAD_SP)
      sp_valid_q <= 1'b1;
  end

  // ****************************************
  // completion and results
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      done_q      <= 1'b0;
      pc_load_q   <= 1'b0;
      pc_target_q <= 32'h0000_0000;
      result_q    <= 16'h0000;
    end
    else
    begin
      done_q    <= 1'b0;
      pc_load_q <= 1'b0;
      if (accept)
      begin
        done_q      <= (state_q == ST_IDLE) && !(op_code_i inside {
                         cpu_exec_pkg::OP_STORE_FLAGS, cpu_exec_pkg::OP_PUSH,
                         cpu_exec_pkg::OP_POP, cpu_exec_pkg::OP_TEST_AND_SET});
        pc_target_q <= op_pc_i + disp_ext;
        unique case (op_code_i)
          cpu_exec_pkg::OP_BRANCH_ALWAYS: pc_load_q <= 1'b1;
          cpu_exec_pkg::OP_BRANCH_NEVER:  pc_load_q <= 1'b0;
          cpu_exec_pkg::OP_JUMP_INDIRECT:
          begin
            pc_load_q   <= 1'b1;
            pc_target_q <= op_addr_i;
          end
          cpu_exec_pkg::OP_DEC_ADJ_ADD,
          cpu_exec_pkg::OP_DEC_ADJ_SUB:   result_q <= {8'h00, adj_value};
          default:                        pc_load_q <= 1'b0;
        endcase
      end
      else if (mif.done && (state_q == ST_TAS_WR || cur_op_q != cpu_exec_pkg::OP_TEST_AND_SET))
      begin
        done_q <= 1'b1;
        if (cur_op_q == cpu_exec_pkg::OP_POP)
          result_q <= mif.rdata[15:0];
        else if (cur_op_q == cpu_exec_pkg::OP_TEST_AND_SET)
          result_q <= {8'h00, wdata_q[7:0]};
      end
    end
  end

  assign done_o      = done_q;
  assign pc_load_o   = pc_load_q;
  assign pc_target_o = pc_target_q;
  assign result_o    = result_q;
  assign flags_o     = flags_q;
  assign sp_o        = sp_q;
  assign sp_valid_o  = sp_valid_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_short_branch: assert property ((accept && op_code_i == cpu_exec_pkg::OP_BRANCH_ALWAYS
      && !op_wide_i) |=> pc_target_o == $past(op_pc_i) + {{24{$past(op_disp_i[7])}}, $past(op_disp_i[7:0])})
    else $error("short branch target wrong");
  a_long_branch: assert property ((accept && op_wide_i
      && op_code_i == cpu_exec_pkg::OP_BRANCH_ALWAYS) |=> pc_target_o == $past(op_pc_i)
      + {{16{$past(op_disp_i[15])}}, $past(op_disp_i)})
    else $error("long branch target wrong");
  a_always_taken: assert property ((accept && op_code_i == cpu_exec_pkg::OP_BRANCH_ALWAYS)
      |=> done_o && pc_load_o) else $error("branch always not taken");
  a_never_taken: assert property ((accept && op_code_i == cpu_exec_pkg::OP_BRANCH_NEVER)
      |=> done_o && !pc_load_o) else $error("branch never was taken");
  a_jump_operand: assert property ((accept && op_code_i == cpu_exec_pkg::OP_JUMP_INDIRECT)
      |=> pc_load_o && pc_target_o == $past(op_addr_i)) else $error("jump target wrong");
  a_xor_flags: assert property ((accept && op_code_i == cpu_exec_pkg::OP_FLAGS_XOR)
      |=> flags_o == ($past(flags_o) ^ $past(op_data_i[7:0]))) else $error("flag xor wrong");
  a_flags_even: assert property ((mem_req_o && cur_op_q == cpu_exec_pkg::OP_STORE_FLAGS)
      |-> !mem_addr_o[0] && mem_size_o == cpu_exec_pkg::SIZE_WORD) else $error("flag store odd");
  a_stack_size: assert property ((mem_req_o && cur_op_q inside {cpu_exec_pkg::OP_PUSH,
      cpu_exec_pkg::OP_POP}) |-> mem_size_o != cpu_exec_pkg::SIZE_BYTE) else $error("byte stack access");
  a_tas_write: assert property ((mem_req_o && state_q == ST_TAS_WR)
      |-> mem_we_o && mem_wdata_o[7]) else $error("test-and-set write lacks bit 7");
  // every cycle of the write-back, not only its first one
  a_tas_locked: assert property ((state_q == ST_TAS_WR)
      |-> !ext_bus_grant_o && lock_q) else $error("bus released");

  c_branch: cover property (accept && op_code_i == cpu_exec_pkg::OP_BRANCH_ALWAYS && op_wide_i);
  c_tas: cover property (state_q == ST_TAS_WR && mif.done);
  c_grant_wait: cover property (ext_bus_grant_o && req_q);
endmodule : cpu_exec_unit
`default_nettype wire

// >>> sim/mem_bus_model.sv
// memory responder on the far side of the execution unit's bus port
`timescale 1ns/100ps
`default_nettype none
module mem_bus_model (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 mem_req_i,
  input  wire logic                 mem_we_i,
  input  wire logic [31:0]          mem_addr_i,
  input  wire cpu_exec_pkg::xfer_size_t mem_size_i,
  input  wire logic [31:0]          mem_wdata_i,
  input  wire logic [2:0]           lat_i,
  output logic                      mem_ack_o,
  output logic      [31:0]          mem_rdata_o,
  output logic      [31:0]          last_addr_o,
  output cpu_exec_pkg::xfer_size_t  last_size_o
);
  // ****************************************
  // storage and response timing
  // ****************************************
  logic [7:0] mem [0:255];
  logic [2:0] cnt_q;
  logic [7:0] a;

  assign a = mem_addr_i[7:0];

  // rdata is only meaningful in the ack cycle; otherwise it toggles so stale use shows up
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_ack_o   <= 1'b0;
      cnt_q       <= 3'h0;
      mem_rdata_o <= 32'h0;
    end
    else if (mem_ack_o || !mem_req_i)
    begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
    end
    else if (cnt_q < lat_i)
    begin
      cnt_q       <= cnt_q + 3'h1;
      mem_rdata_o <= ~mem_rdata_o;
    end
    else
    begin
      mem_ack_o   <= 1'b1;
      cnt_q       <= 3'h0;
      last_addr_o <= mem_addr_i;
      last_size_o <= mem_size_i;
      if (mem_size_i == cpu_exec_pkg::SIZE_BYTE)
      begin
        mem_rdata_o <= {24'h0, mem[a]};
        if (mem_we_i)
          mem[a] <= mem_wdata_i[7:0];
      end
      else
      begin
        mem_rdata_o <= {16'h0, mem[a], mem[a+8'h1]};
        if (mem_we_i)
        begin
          mem[a]      <= mem_wdata_i[15:8];
          mem[a+8'h1] <= mem_wdata_i[7:0];
        end
      end
    end
  end
endmodule : mem_bus_model
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench of the execution unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk_i, rst_i, op_valid_i, op_wide_i, ext_bus_req_i;
  cpu_exec_pkg::op_code_t op_code_i;
  logic [31:0] op_pc_i, op_addr_i, mem_addr_o, mem_wdata_o, mem_rdata_i, pc_target_o, sp_o;
  logic [15:0] op_disp_i, op_data_i, result_o;
  logic [7:0]  flags_o;
  logic [2:0]  lat;
  logic op_ready_o, done_o, pc_load_o, sp_valid_o, mem_req_o, mem_we_o, mem_ack_i;
  logic ext_bus_grant_o;
  cpu_exec_pkg::xfer_size_t mem_size_o, last_size;
  logic [31:0] last_addr;
  int bad_count, tests_run, cycles;

  cpu_exec_unit uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
    .op_ready_o(op_ready_o), .op_code_i(op_code_i), .op_wide_i(op_wide_i), .op_pc_i(op_pc_i),
    .op_disp_i(op_disp_i), .op_addr_i(op_addr_i), .op_data_i(op_data_i), .done_o(done_o),
    .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .result_o(result_o), .flags_o(flags_o),
    .sp_o(sp_o), .sp_valid_o(sp_valid_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o), .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .ext_bus_req_i(ext_bus_req_i),
    .ext_bus_grant_o(ext_bus_grant_o));

  mem_bus_model mem_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_size_i(mem_size_o),
    .mem_wdata_i(mem_wdata_o), .lat_i(lat), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i),
    .last_addr_o(last_addr), .last_size_o(last_size));

  // ****************************************
  // clock, timeout and common tasks
  // ****************************************
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // whole run needs well under a thousand cycles
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // offers one op, then waits for done; checks grant stays low while waiting if asked
  task automatic do_op(input cpu_exec_pkg::op_code_t c, input logic w, input logic [31:0] pc,
                       input logic [15:0] d, input logic [31:0] ad, input logic [15:0] dt,
                       input logic no_grant);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b1;
    op_code_i  <= c;
    op_wide_i  <= w;
    op_pc_i    <= pc;
    op_disp_i  <= d;
    op_addr_i  <= ad;
    op_data_i  <= dt;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b0;
    // other master asks only once the op is taken, so an earlier grant is not mistaken
    if (no_grant)
      ext_bus_req_i <= 1'b1;
    @(negedge ref_clk_i);
    while (done_o !== 1'b1 && n < 100)
    begin
      if (no_grant)
        check(ext_bus_grant_o, 1'b0);
      n++;
      @(negedge ref_clk_i);
    end
    check(done_o, 1'b1);
  endtask : do_op

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check({op_ready_o, done_o, pc_load_o, mem_req_o, ext_bus_grant_o}, 5'h10);
    check(flags_o, 8'h00);
    check(sp_valid_o, 1'b0);
  endtask : t_reset

  task automatic t_branch();
    logic [31:0] pcs [5] = '{32'h1000, 32'h1000, 32'h1000, 32'h0001_0000, 32'h1000};
    logic [15:0] ds [5]  = '{16'h007f, 16'h0080, 16'h7fff, 16'h8000, 16'h12fe};
    logic        ws [5]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] ts [5]  = '{32'h107f, 32'h0f80, 32'h8fff, 32'h8000, 32'h0ffe};
    for (int i = 0; i < 5; i++)
    begin
      do_op(cpu_exec_pkg::OP_BRANCH_ALWAYS, ws[i], pcs[i], ds[i], 32'h0, 16'h0, 1'b0);
      check(pc_load_o, 1'b1);
      check(pc_target_o, ts[i]);
      do_op(cpu_exec_pkg::OP_BRANCH_NEVER, ws[i], pcs[i], ds[i], 32'h0, 16'h0, 1'b0);
      check(pc_load_o, 1'b0);
    end
    do_op(cpu_exec_pkg::OP_JUMP_INDIRECT, 1'b0, 32'h1000, 16'h0010, 32'h0002_4680, 16'h0, 1'b0);
    check(pc_load_o, 1'b1);
    check(pc_target_o, 32'h0002_4680);
  endtask : t_branch

  task automatic t_flags_store();
    do_op(cpu_exec_pkg::OP_FLAGS_XOR, 1'b0, 32'h0, 16'h0, 32'h0, 16'h00a0, 1'b0);
    check(flags_o, 8'ha0);
    lat <= 3'h2;
    do_op(cpu_exec_pkg::OP_STORE_FLAGS, 1'b0, 32'h0, 16'h0, 32'h21, 16'h0, 1'b0);
    check(last_addr, 32'h20);
    check(last_size, cpu_exec_pkg::SIZE_WORD);
    check(mem_model.mem[8'h20], 8'ha0);
    do_op(cpu_exec_pkg::OP_FLAGS_XOR, 1'b0, 32'h0, 16'h0, 32'h0, 16'h00a0, 1'b0);
    check(flags_o, 8'h00);
  endtask : t_flags_store

  task automatic t_tas();
    logic [7:0] olds [3] = '{8'h05, 8'h00, 8'h80};
    logic [7:0] fl [3]   = '{8'h00, 8'h04, 8'h08};
    lat <= 3'h3;
    for (int i = 0; i < 3; i++)
    begin
      mem_model.mem[8'h30 + i] = olds[i];
      do_op(cpu_exec_pkg::OP_TEST_AND_SET, 1'b0, 32'h0, 16'h0, 32'h30 + i, 16'h0, 1'b1);
      check(mem_model.mem[8'h30 + i], olds[i] | 8'h80);
      check(last_size, cpu_exec_pkg::SIZE_BYTE);
      check(result_o, {8'h00, olds[i] | 8'h80});
      check(flags_o, fl[i]);
      repeat (2) @(negedge ref_clk_i);
      check(ext_bus_grant_o, 1'b1);
      @(posedge ref_clk_i);
      ext_bus_req_i <= 1'b0;
      repeat (2) @(negedge ref_clk_i);
      check(ext_bus_grant_o, 1'b0);
      if (i == 1)
      begin
        do_op(cpu_exec_pkg::OP_FLAGS_XOR, 1'b0, 32'h0, 16'h0, 32'h0, 16'h00a0, 1'b0);
        check(flags_o, 8'ha4);
        do_op(cpu_exec_pkg::OP_FLAGS_XOR, 1'b0, 32'h0, 16'h0, 32'h0, 16'h00a0, 1'b0);
      end
    end
  endtask : t_tas

  task automatic t_decimal();
    do_op(cpu_exec_pkg::OP_DEC_ADJ_ADD, 1'b0, 32'h0, 16'h0, 32'h0, 16'h003a, 1'b0);
    check(result_o[7:0], 8'h40);
    check(flags_o[7], 1'b0);
    // carry and half-carry inverted before the add-side adjust; both stay set for the subtract-side one
    do_op(cpu_exec_pkg::OP_FLAGS_XOR, 1'b0, 32'h0, 16'h0, 32'h0, 16'h00a0, 1'b0);
    do_op(cpu_exec_pkg::OP_DEC_ADJ_ADD, 1'b0, 32'h0, 16'h0, 32'h0, 16'h0000, 1'b0);
    check(result_o[7:0], 8'h66);
    check(flags_o[7], 1'b1);
    do_op(cpu_exec_pkg::OP_DEC_ADJ_SUB, 1'b0, 32'h0, 16'h0, 32'h0, 16'h0000, 1'b0);
    check(result_o[7:0], 8'h9a);
    check(flags_o[7], 1'b1);
  endtask : t_decimal

  task automatic t_stack();
    lat <= 3'h0;
    // even value, halfway up a 256-byte ram ending at ff
    do_op(cpu_exec_pkg::OP_LOAD_SP, 1'b0, 32'h0, 16'h0, 32'h80, 16'h0, 1'b0);
    check(sp_valid_o, 1'b1);
    check(sp_o, 32'h80);
    do_op(cpu_exec_pkg::OP_PUSH, 1'b0, 32'h0, 16'h0, 32'h0, 16'h1234, 1'b0);
    check(sp_o, 32'h7e);
    check(last_addr, 32'h7e);
    check(last_size, cpu_exec_pkg::SIZE_WORD);
    do_op(cpu_exec_pkg::OP_POP, 1'b0, 32'h0, 16'h0, 32'h0, 16'h0, 1'b0);
    check(result_o, 16'h1234);
    check(sp_o, 32'h80);
    check(last_size, cpu_exec_pkg::SIZE_WORD);
  endtask : t_stack

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    bad_count     = 0;
    tests_run     = 0;
    cycles        = 0;
    rst_i         = 1'b1;
    op_valid_i    = 1'b0;
    op_code_i     = cpu_exec_pkg::OP_BRANCH_NEVER;
    op_wide_i     = 1'b0;
    op_pc_i       = 32'h0;
    op_disp_i     = 16'h0;
    op_addr_i     = 32'h0;
    op_data_i     = 16'h0;
    ext_bus_req_i = 1'b0;
    lat           = 3'h1;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    t_reset();
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_branch();
    t_flags_store();
    t_tas();
    t_decimal();
    t_stack();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
